// >>> hw/tdc_servo.sv
// drum and capstan speed/phase servo with axi4-lite control
//
// Contract
// - drum speed error is each measured tach period against a reference count.
// - in record the drum speed reference is one fixed count for every speed mode.
// - in record drum phase is the turn pulse timing against halved line sync.
// - speed and phase error of a motor are summed and steer its drive toward zero error.
// - capstan speed error is its tach period against a count chosen by speed mode.
// - in record divided capstan tach is timed against a counted frame with a fixed reference.
// - the capstan tach divider is 36, 18 or 12 for standard, long and extended play.
// - capstan references assume 360 tach pulses per turn at 3, 1.5 or 1 Hz.
// - in record control pulses are emitted on the halved line sync event.
// - in playback the drum speed reference follows the tape speed mode.
// - in playback drum phase is the turn pulse period against a speed-dependent count.
// - in playback control pulses are inputs timed against a speed-dependent reference.
`timescale 1ns/1ps
module tdc_servo #(
  parameter int unsigned CW = tdc_pkg::CNT_W,
  parameter int unsigned LW = tdc_pkg::LVL_W
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          drum_tach_pulse,
  input  wire logic          drum_turn_pulse,
  input  wire logic          capstan_tach_pulse,
  input  wire logic          line_sync,
  input  wire logic          control_pulse_i,
  output logic               control_pulse_o,
  output logic               control_pulse_oe,
  output logic               drum_drive_level,
  output logic               capstan_drive_level
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, edge when stage two is high while stage three is still low
  logic [4:0] pin_raw;
  logic [4:0] s1_q, s2_q, s3_q;
  logic [4:0] rise;
  assign pin_raw = {control_pulse_i, line_sync, capstan_tach_pulse,
                    drum_turn_pulse, drum_tach_pulse};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // mode control
  logic              rec_q;
  tdc_pkg::tdc_speed_t spd_q;
  logic              ctrl_wr;
  logic [31:0]       wdata_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_q <= tdc_pkg::CTRL_RESET[tdc_pkg::CTRL_REC_BIT];
      spd_q <= tdc_pkg::tdc_speed_t'(tdc_pkg::CTRL_RESET[2:1]);
    end else if (ctrl_wr) begin
      rec_q <= wdata_q[tdc_pkg::CTRL_REC_BIT];
      // the unused code 2'b11 is refused, the old mode stays
      if (wdata_q[tdc_pkg::CTRL_SPD_LSB +: 2] != 2'b11)
        spd_q <= tdc_pkg::tdc_speed_t'(wdata_q[tdc_pkg::CTRL_SPD_LSB +: 2]);
    end
  end

  // reference selection
  logic [CW-1:0] fh_adj, drum_spd_ref, cap_spd_ref, cap_ph_ref;
  logic [7:0]    cap_div;
  always_comb begin
    case (spd_q)
      tdc_pkg::tdc_long_play: begin
        fh_adj      = tdc_pkg::FH_ADJ_LP;
        cap_spd_ref = tdc_pkg::CAP_SPD_REF_LP;
        cap_div     = tdc_pkg::CAP_DIV_LP;
      end
      tdc_pkg::tdc_extended_play: begin
        fh_adj      = tdc_pkg::FH_ADJ_EP;
        cap_spd_ref = tdc_pkg::CAP_SPD_REF_EP;
        cap_div     = tdc_pkg::CAP_DIV_EP;
      end
      default: begin
        fh_adj      = tdc_pkg::FH_ADJ_SP;
        cap_spd_ref = tdc_pkg::CAP_SPD_REF_SP;
        cap_div     = tdc_pkg::CAP_DIV_SP;
      end
    endcase
    drum_spd_ref = rec_q ? tdc_pkg::DRUM_SPD_REF_REC
                         : tdc_pkg::DRUM_SPD_REF_REC + fh_adj;
    cap_ph_ref   = rec_q ? tdc_pkg::CAP_PH_REF_REC
                         : tdc_pkg::CAP_PH_REF_REC + fh_adj;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame event from halved line sync, theoretical frame timer
  logic          half_q, frame_evt;
  logic [CW-1:0] frame_tmr_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) half_q <= 1'b0;
    else if (rise[3]) half_q <= ~half_q;
  end
  assign frame_evt = rise[3] & half_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) frame_tmr_q <= '0;
    else if (frame_tmr_q == tdc_pkg::FRAME_CNT - 1'b1) frame_tmr_q <= '0;
    else frame_tmr_q <= frame_tmr_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // period counters, saturating so a stalled motor reads as very slow
  logic [CW-1:0] dt_cnt_q, dp_cnt_q, ct_cnt_q, ph_cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dt_cnt_q <= '0;
      dp_cnt_q <= '0;
      ct_cnt_q <= '0;
      ph_cnt_q <= '0;
    end else begin
      dt_cnt_q <= rise[0] ? CW'(1) : dt_cnt_q + CW'(~&dt_cnt_q); // n clocks read as n
      dp_cnt_q <= rise[1] ? CW'(1) : dp_cnt_q + CW'(~&dp_cnt_q);
      ct_cnt_q <= rise[2] ? CW'(1) : ct_cnt_q + CW'(~&ct_cnt_q);
      ph_cnt_q <= frame_evt ? CW'(1) : ph_cnt_q + CW'(~&ph_cnt_q);
    end
  end

  // capstan tach divided to frame rate
  logic [7:0] div_q;
  logic       cap_frame;
  assign cap_frame = rise[2] && (div_q >= cap_div - 8'h01);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) div_q <= 8'h00;
    else if (cap_frame) div_q <= 8'h00;
    else if (rise[2]) div_q <= div_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // error capture
  logic signed [CW:0] d_spd_q, d_ph_q, c_spd_q, c_ph_q;
  logic               d_done_q, c_done_q;
  logic [CW-1:0]      d_per_q, c_per_q;
  logic               d_ph_evt, c_ph_evt;
  logic [CW-1:0]      d_ph_meas, d_ph_ref;

  function automatic logic signed [CW:0] diff(input logic [CW-1:0] a,
                                             input logic [CW-1:0] b);
    diff = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction
  assign d_ph_evt  = rise[1];
  assign d_ph_meas = rec_q ? ph_cnt_q : dp_cnt_q;
  assign d_ph_ref  = rec_q ? tdc_pkg::DRUM_PH_REF_REC
                           : tdc_pkg::FRAME_CNT + fh_adj;
  assign c_ph_evt  = rec_q ? cap_frame : rise[4];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_spd_q  <= '0;
      d_ph_q   <= '0;
      d_per_q  <= '0;
      d_done_q <= 1'b0;
    end else begin
      d_done_q <= rise[0] | d_ph_evt;
      if (rise[0]) begin
        d_per_q <= dt_cnt_q;
        d_spd_q <= diff(dt_cnt_q, drum_spd_ref);
      end
      if (d_ph_evt) d_ph_q <= diff(d_ph_meas, d_ph_ref);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_spd_q  <= '0;
      c_ph_q   <= '0;
      c_per_q  <= '0;
      c_done_q <= 1'b0;
    end else begin
      c_done_q <= rise[2] | c_ph_evt;
      if (rise[2]) begin
        c_per_q <= ct_cnt_q;
        c_spd_q <= diff(ct_cnt_q, cap_spd_ref);
      end
      if (c_ph_evt) c_ph_q <= diff(frame_tmr_q, cap_ph_ref);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mix: step limited so one bad pulse cannot slam the motor
  function automatic logic [LW-1:0] mix(input logic [LW-1:0] lvl,
                                        input logic signed [CW:0] spd,
                                        input logic signed [CW:0] ph);
    logic signed [CW+1:0] sum;
    logic signed [CW+1:0] st;
    logic signed [CW+1:0] nx;
    sum = (CW+2)'(spd) + (CW+2)'(ph);
    st  = sum >>> tdc_pkg::STEP_SHIFT;
    if (st > (CW+2)'(tdc_pkg::STEP_MAX)) st = (CW+2)'(tdc_pkg::STEP_MAX);
    if (st < -(CW+2)'(tdc_pkg::STEP_MAX)) st = -(CW+2)'(tdc_pkg::STEP_MAX);
    nx = $signed({{(CW+2-LW){1'b0}}, lvl}) + st;
    if (nx < 0) mix = '0;
    else if (nx > $signed((CW+2)'({LW{1'b1}}))) mix = {LW{1'b1}};
    else mix = nx[LW-1:0];
  endfunction

  logic [LW-1:0] d_lvl_q, c_lvl_q, pwm_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_lvl_q <= tdc_pkg::LVL_RESET;
      c_lvl_q <= tdc_pkg::LVL_RESET;
    end else begin
      if (d_done_q) d_lvl_q <= mix(d_lvl_q, d_spd_q, d_ph_q);
      if (c_done_q) c_lvl_q <= mix(c_lvl_q, c_spd_q, c_ph_q);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_q               <= '0;
      drum_drive_level    <= 1'b0;
      capstan_drive_level <= 1'b0;
    end else begin
      pwm_q               <= pwm_q + 1'b1;
      drum_drive_level    <= pwm_q < d_lvl_q;
      capstan_drive_level <= pwm_q < c_lvl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control pulse: driven in record, released in playback
  logic [15:0] ctl_cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_cnt_q        <= 16'h0000;
      control_pulse_o  <= 1'b0;
      control_pulse_oe <= 1'b0;
    end else begin
      control_pulse_oe <= rec_q;
      if (rec_q && frame_evt) ctl_cnt_q <= tdc_pkg::CTL_PULSE_CYC;
      else if (ctl_cnt_q != 16'h0000) ctl_cnt_q <= ctl_cnt_q - 16'h0001;
      control_pulse_o <= rec_q && (ctl_cnt_q != 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, address and data taken in either order
  logic       aw_have_q, w_have_q, w_strb0_q;
  logic [7:0] awaddr_q;
  assign ctrl_wr = aw_have_q && w_have_q && !s_axi_bvalid &&
                   awaddr_q == tdc_pkg::REG_CTRL && w_strb0_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      w_strb0_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tdc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        w_strb0_q    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // level and period registers are read-only, writes there are ignored
        s_axi_bresp  <= (awaddr_q <= tdc_pkg::REG_CAP_PER && awaddr_q[1:0] == 2'b00)
                        ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= tdc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= tdc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        tdc_pkg::REG_CTRL:     s_axi_rdata <= {29'h0, spd_q, rec_q};
        tdc_pkg::REG_DRUM_LVL: s_axi_rdata <= 32'(d_lvl_q);
        tdc_pkg::REG_CAP_LVL:  s_axi_rdata <= 32'(c_lvl_q);
        tdc_pkg::REG_DRUM_PER: s_axi_rdata <= 32'(d_per_q);
        tdc_pkg::REG_CAP_PER:  s_axi_rdata <= 32'(c_per_q);
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= tdc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // tdc_servo

// >>> hw/tdc_pkg.sv
// constants, register map and mode types of the drum and capstan servo
package tdc_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned FRAME_HZ      = 30;
  localparam int unsigned CNT_W         = 24;
  // drum tach pulses per head turn (not fixed by the mechanism, adjust per drum)
  localparam int unsigned DRUM_TACH_PER_TURN = 5;
  localparam int unsigned CAP_TACH_PER_REV   = 360;
  // capstan rotation rate in millihertz per speed mode
  localparam int unsigned CAP_RATE_MHZ_SP = 3000;
  localparam int unsigned CAP_RATE_MHZ_LP = 1500;
  localparam int unsigned CAP_RATE_MHZ_EP = 1000;
  localparam logic [7:0]  CAP_DIV_SP = 8'h24;
  localparam logic [7:0]  CAP_DIV_LP = 8'h12;
  localparam logic [7:0]  CAP_DIV_EP = 8'h0c;

  typedef enum logic [1:0] {
    tdc_standard_play = 2'b00,
    tdc_long_play     = 2'b01,
    tdc_extended_play = 2'b10
  } tdc_speed_t;

  localparam logic [CNT_W-1:0] FRAME_CNT = CNT_W'(CLK_HZ / FRAME_HZ);
  localparam logic [CNT_W-1:0] DRUM_SPD_REF_REC =
    CNT_W'(CLK_HZ / (FRAME_HZ * DRUM_TACH_PER_TURN));
  localparam logic [CNT_W-1:0] CAP_SPD_REF_SP =
    CNT_W'((CLK_HZ / CAP_TACH_PER_REV) * 1000 / CAP_RATE_MHZ_SP);
  localparam logic [CNT_W-1:0] CAP_SPD_REF_LP =
    CNT_W'((CLK_HZ / CAP_TACH_PER_REV) * 1000 / CAP_RATE_MHZ_LP);
  localparam logic [CNT_W-1:0] CAP_SPD_REF_EP =
    CNT_W'((CLK_HZ / CAP_TACH_PER_REV) * 1000 / CAP_RATE_MHZ_EP);
  // line-rate correction offsets in playback, counts per speed mode
  localparam logic [CNT_W-1:0] FH_ADJ_SP = 24'h000000;
  localparam logic [CNT_W-1:0] FH_ADJ_LP = 24'h000010;
  localparam logic [CNT_W-1:0] FH_ADJ_EP = 24'h000020;
  localparam logic [CNT_W-1:0] DRUM_PH_REF_REC = CNT_W'(CLK_HZ / (FRAME_HZ * 4));
  localparam logic [CNT_W-1:0] CAP_PH_REF_REC  = CNT_W'(CLK_HZ / (FRAME_HZ * 2));

  localparam int unsigned CTL_PULSE_NS  = 50_000;
  localparam logic [15:0] CTL_PULSE_CYC = 16'(CTL_PULSE_NS * (CLK_HZ / 1_000_000) / 1000);

  localparam int unsigned LVL_W      = 10;
  localparam logic [LVL_W-1:0] LVL_RESET = 10'h200;
  localparam int unsigned STEP_SHIFT = 4;
  localparam int signed   STEP_MAX   = 8;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_DRUM_LVL  = 8'h04;
  localparam logic [7:0] REG_CAP_LVL   = 8'h08;
  localparam logic [7:0] REG_DRUM_PER  = 8'h0c;
  localparam logic [7:0] REG_CAP_PER   = 8'h10;
  localparam int unsigned CTRL_REC_BIT = 0;
  localparam int unsigned CTRL_SPD_LSB = 1;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// >>> tb/tdc_servo_checker.sv
// checker for bus handshakes, control pulses and drive pwm of the servo
`timescale 1ns/1ps
module tdc_servo_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        control_pulse_o,
  input wire logic        control_pulse_oe,
  input wire logic        drum_drive_level,
  input wire logic        capstan_drive_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // counts high time; a repetition of 2500 would choke the tools
  logic [15:0] hi_cnt_q;
  // pwm high runs; a 1023-cycle delay range is past what the tools take
  logic [10:0] drum_hi_q, cap_hi_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt_q  <= 16'h0000;
      drum_hi_q <= 11'h000;
      cap_hi_q  <= 11'h000;
    end else begin
      hi_cnt_q  <= control_pulse_o ? hi_cnt_q + 16'h0001 : 16'h0000;
      drum_hi_q <= drum_drive_level ? drum_hi_q + 11'h001 : 11'h000;
      cap_hi_q  <= capstan_drive_level ? cap_hi_q + 11'h001 : 11'h000;
    end
  end
  //////////////////////////////////////////////////////////////
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  write_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  ctl_dir_a:
    assert property (control_pulse_o |-> control_pulse_oe)
    else $error("control pulse driven without enable");
  ctl_width_a:
    assert property ($fell(control_pulse_o) && control_pulse_oe |-> hi_cnt_q == 16'h09c4)
    else $error("control pulse width wrong");
  drum_pwm_a:
    assert property (drum_hi_q <= 11'h3ff)
    else $error("drum pwm high too long");
  cap_pwm_a:
    assert property (cap_hi_q <= 11'h3ff)
    else $error("capstan pwm high too long");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(control_pulse_o));
endmodule // tdc_servo_checker

bind tdc_servo tdc_servo_checker tdc_servo_checker_inst (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .control_pulse_o(control_pulse_o),
  .control_pulse_oe(control_pulse_oe), .drum_drive_level(drum_drive_level),
  .capstan_drive_level(capstan_drive_level)
);

// >>> tb/tdc_motor_model.sv
// tach sensors and sync source feeding the servo pins
`timescale 1ns/1ps
module tdc_motor_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        run,
  input  wire logic        turn_en,
  input  wire logic [15:0] drum_per,
  input  wire logic [15:0] cap_per,
  input  wire logic [15:0] line_per,
  output logic             drum_tach_pulse,
  output logic             drum_turn_pulse,
  output logic             capstan_tach_pulse,
  output logic             line_sync,
  output logic             ctl_drive
);
  logic [15:0] drum_q, cap_q, line_q;
  logic        half_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drum_q <= 16'h0000;
      cap_q  <= 16'h0000;
      line_q <= 16'h0000;
      half_q <= 1'b0;
    end else if (run) begin
      drum_q <= (drum_q >= drum_per - 16'h0001) ? 16'h0000 : drum_q + 16'h0001;
      cap_q  <= (cap_q >= cap_per - 16'h0001) ? 16'h0000 : cap_q + 16'h0001;
      line_q <= (line_q >= line_per - 16'h0001) ? 16'h0000 : line_q + 16'h0001;
      if (line_q == 16'h0000) half_q <= ~half_q;
    end
  end
  // four-cycle pulses so the three-flop synchronizer never misses one
  assign drum_tach_pulse    = run && drum_q < 16'h0004;
  assign drum_turn_pulse    = turn_en && drum_tach_pulse;
  assign capstan_tach_pulse = run && cap_q < 16'h0004;
  assign line_sync          = run && line_q < 16'h0004;
  // playback control track: one pulse per line period, one and three cycles wide in turn
  assign ctl_drive          = line_sync && half_q;
endmodule // tdc_motor_model

// >>> tb/tape_drum_capstan_servo_bench.sv
// self-checking bench for the drum and capstan servo
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tape_drum_capstan_servo_bench;
  logic        clk, rst_b, run, turn_en, pulse_seen, ctl_drive;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, exp_d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        drum_tach_pulse, drum_turn_pulse, capstan_tach_pulse, line_sync;
  logic        control_pulse_i, control_pulse_o, control_pulse_oe;
  logic        drum_drive_level, capstan_drive_level;
  logic [15:0] drum_per, cap_per, line_per;
  logic [2:0]  ctrl_old;
  int          failures, cmp_count, cyc;

  // shared control line: whoever has the enable owns the wire
  assign control_pulse_i = control_pulse_oe ? control_pulse_o : ctl_drive;

  tdc_servo tdc_servo_inst (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drum_tach_pulse, .drum_turn_pulse,
    .capstan_tach_pulse, .line_sync, .control_pulse_i, .control_pulse_o,
    .control_pulse_oe, .drum_drive_level, .capstan_drive_level);
  tdc_motor_model tdc_motor_model_inst (.clk, .rst_b, .run, .turn_en, .drum_per, .cap_per,
    .line_per, .drum_tach_pulse, .drum_turn_pulse, .capstan_tach_pulse, .line_sync,
    .ctl_drive);
  //////////////////////////////////////////////////////////////
  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (control_pulse_o === 1'b1) pulse_seen <= 1'b1;
    cyc++;
    if (cyc == 60000) begin
      failures++;
      give_verdict();
    end
  end

  function automatic logic [31:0] ctrl_exp(input logic [2:0] old, input logic [2:0] w);
    return {29'h0, (w[2:1] == 2'b11) ? old[2:1] : w[2:1], w[0]};
  endfunction

  // ready goes up with the request; one idle edge keeps back-to-back calls apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic new_per();
    drum_per <= 16'(1500 + $urandom % 1000);
    cap_per  <= 16'(1500 + $urandom % 1000);
  endtask

  task automatic check_meas();
    rd(tdc_pkg::REG_DRUM_PER, rd_d, rd_r);
    `CHK("drum_period", {16'h0, drum_per}, rd_d)
    rd(tdc_pkg::REG_CAP_PER, rd_d, rd_r);
    `CHK("cap_period", {16'h0, cap_per}, rd_d)
  endtask

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    {clk, rst_b, run, turn_en, pulse_seen} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {drum_per, cap_per, line_per} = {16'h07d0, 16'h07d0, 16'h0800};
    failures = 0;
    cmp_count = 0;
    rd_d = $urandom(32'h62a7);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(tdc_pkg::REG_CTRL, rd_d, rd_r);
    `CHK("ctrl_rst", 32'h0, rd_d)
    wr(tdc_pkg::REG_DRUM_LVL, 32'h0, rd_r);
    `CHK("ro_resp", tdc_pkg::RESP_OKAY, rd_r)
    rd(tdc_pkg::REG_DRUM_LVL, rd_d, rd_r);
    `CHK("drum_lvl_rst", {22'h0, tdc_pkg::LVL_RESET}, rd_d)
    rd(8'h14, rd_d, rd_r);
    `CHK("unmapped_resp", tdc_pkg::RESP_SLVERR, rd_r)
    `CHK("unmapped_data", 32'h0, rd_d)
    wr(8'h02, 32'h1, rd_r);
    `CHK("unaligned_resp", tdc_pkg::RESP_SLVERR, rd_r)
    ctrl_old = 3'h0;
    // every mode code, including the refused speed code
    for (int i = 0; i < 8; i++) begin
      wr(tdc_pkg::REG_CTRL, 32'(i), rd_r);
      rd(tdc_pkg::REG_CTRL, rd_d, rd_r);
      exp_d = ctrl_exp(ctrl_old, 3'(i));
      `CHK("ctrl_rw", exp_d, rd_d)
      ctrl_old = exp_d[2:0];
    end
    // lane 0 not enabled: the mode must not move
    s_axi_wstrb <= 4'he;
    wr(tdc_pkg::REG_CTRL, 32'h0, rd_r);
    s_axi_wstrb <= 4'hf;
    rd(tdc_pkg::REG_CTRL, rd_d, rd_r);
    `CHK("ctrl_strb", {29'h0, ctrl_old}, rd_d)
    wr(tdc_pkg::REG_CTRL, 32'h1, rd_r);
    new_per();
    run <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("oe_rec", 1'b1, control_pulse_oe)
    repeat (20000) @(posedge clk);
    `CHK("ctl_pulse", 1'b1, pulse_seen)
    check_meas();
    // tach far faster than the reference must pull both drives down
    rd(tdc_pkg::REG_DRUM_LVL, rd_d, rd_r);
    `CHK("drum_down", 1'b1, rd_d < 32'h00000200)
    rd(tdc_pkg::REG_CAP_LVL, rd_d, rd_r);
    `CHK("cap_down", 1'b1, rd_d < 32'h00000200)
    turn_en <= 1'b1;
    for (int s = 1; s < 3; s++) begin
      wr(tdc_pkg::REG_CTRL, 32'(s << 1), rd_r);
      new_per();
      repeat (2) @(posedge clk);
      `CHK("oe_play", 1'b0, control_pulse_oe)
      repeat (8000) @(posedge clk);
      check_meas();
    end
    give_verdict();
  end
endmodule // tape_drum_capstan_servo_bench
